// ==== hdl/eak_pkg.sv ====
// constants shared by the egress access-control key builder
// assumes one core clock and an apb master for the control registers
//
// Overview of operation
// - each frame's classification, except with the undefined selector 4, builds a key that is sent to the tcam search
// - keys are three, six or twelve words long depending on the variant
// - fields are packed back to back starting at key bit 0
// - six-word keys hold the type in bits 3:0 and the pass flag in bit 4
// - six-word type codes: 0 ethertype, 1 arp, 2 ipv4 transport, 3 ipv4 misc, 5 ipv6
// - the pass flag is high for the first lookup and low for the second
// - every key carries a flag showing protection is active
// - multicast flag equals bit 40 of the destination mac address
// - broadcast flag is high only for an all-ones destination mac address
// - service flag is high for a nonzero service index, and the 12-bit index is carried
// - tagged flag is high when the frame arrived with a vlan tag
package eak_pkg;

  // ----------------------------------------
  // key geometry
  // ----------------------------------------
  localparam int KEY_WORD_W = 32;
  localparam int KEY_MAX_WORDS = 12;
  localparam int KEY_W = KEY_WORD_W * KEY_MAX_WORDS;
  localparam int GRP_W = 8;
  localparam int SVC_IDX_W = 12;
  localparam int VID_W = 13;
  localparam int MAC_W = 48;
  localparam int MC_BIT = 40;
  localparam int COMMON_W = GRP_W + 4 + SVC_IDX_W + 1 + VID_W;
  localparam int TYPE_LSB = 0;
  localparam int TYPE_W = 4;
  localparam int FIRST_POS_WIDE = 4;
  localparam int FIRST_POS_NARROW = 0;
  localparam logic [3:0] WORDS_THREE = 4'h3;
  localparam logic [3:0] WORDS_SIX = 4'h6;
  localparam logic [3:0] WORDS_TWELVE = 4'hc;

  // ----------------------------------------
  // variant selectors; six-word ones equal their type code
  // ----------------------------------------
  localparam logic [2:0] SEL_MAC_ETHERTYPE = 3'h0;
  localparam logic [2:0] SEL_ARP = 3'h1;
  localparam logic [2:0] SEL_IPV4_TRANSPORT = 3'h2;
  localparam logic [2:0] SEL_IPV4_MISC = 3'h3;
  localparam logic [2:0] SEL_IPV6_VLAN = 3'h5;
  localparam logic [2:0] SEL_IPV4_VLAN = 3'h6;
  localparam logic [2:0] SEL_IP_SEVEN_FIELD = 3'h7;

  // ----------------------------------------
  // apb register map
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FRAMES = 8'h08;
  localparam logic [7:0] OFS_REFUSED = 8'h0c;
  localparam logic [7:0] OFS_KEYS = 8'h10;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SECOND_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  typedef enum logic [2:0] {
    EAK_IDLE = 3'b001,
    EAK_FIRST = 3'b010,
    EAK_SECOND = 3'b100
  } eak_state_t;

  function automatic logic eak_is_six_word(input logic [2:0] sel);
    eak_is_six_word = (sel == SEL_MAC_ETHERTYPE) || (sel == SEL_ARP) || (sel == SEL_IPV4_TRANSPORT) ||
                      (sel == SEL_IPV4_MISC) || (sel == SEL_IPV6_VLAN);
  endfunction : eak_is_six_word

endpackage : eak_pkg

// ==== hdl/eak_common_fields.sv ====
// flag derivation and packing of the fields every key variant shares
// assumes classification inputs are stable while the caller samples them
`timescale 1ns/1ps
module eak_common_fields
  import eak_pkg::*;
(
  input wire logic [GRP_W-1:0] aclGroupId,
  input wire logic protectionActive,
  input wire logic [MAC_W-1:0] destMac,
  input wire logic [SVC_IDX_W-1:0] ingressServiceIndex,
  input wire logic taggedOnReceive,
  input wire logic [VID_W-1:0] classifiedVlanId,
  output logic [COMMON_W-1:0] commonFields
);

  logic destMulticastFlag;
  logic destBroadcastFlag;
  logic serviceFrameFlag;

  assign destMulticastFlag = destMac[MC_BIT];
  assign destBroadcastFlag = &destMac;
  assign serviceFrameFlag = |ingressServiceIndex;

  // field order, highest first; flags and ids
  assign commonFields = {classifiedVlanId, taggedOnReceive, ingressServiceIndex, serviceFrameFlag,
                         destBroadcastFlag, destMulticastFlag, protectionActive, aclGroupId};

endmodule : eak_common_fields

// ==== hdl/eak_key_place.sv ====
// places the shared fields into a key of the selected variant
// assumes commonFields comes from eak_common_fields
`timescale 1ns/1ps
module eak_key_place
  import eak_pkg::*;
(
  input wire logic [2:0] keySel,
  input wire logic firstLookup,
  input wire logic [COMMON_W-1:0] commonFields,
  output logic [KEY_W-1:0] keyBits,
  output logic [3:0] keyWords,
  output logic keyDefined
);

  always_comb begin
    keyBits = '0;
    keyWords = WORDS_SIX;
    keyDefined = 1'b1;
    if (eak_is_six_word(keySel)) begin
      // type in 3:0, pass flag in 4; selector equals type code
      keyBits[TYPE_LSB +: TYPE_W] = {1'b0, keySel};
      keyBits[FIRST_POS_WIDE] = firstLookup;
      keyBits[FIRST_POS_WIDE+1 +: COMMON_W] = commonFields;
      keyWords = WORDS_SIX;
    end else begin
      keyBits[FIRST_POS_NARROW] = firstLookup;
      keyBits[FIRST_POS_NARROW+1 +: COMMON_W] = commonFields;
      case (keySel)
        SEL_IPV4_VLAN: begin
          keyWords = WORDS_THREE;
        end
        SEL_IP_SEVEN_FIELD: begin
          keyWords = WORDS_TWELVE;
        end
        default: begin
          keyBits = '0;
          keyWords = 4'h0;
          keyDefined = 1'b0;
        end
      endcase
    end
  end

endmodule : eak_key_place

// ==== hdl/eak_key_builder.sv ====
// egress access-control key builder: frame request in, two lookup keys out
// assumes an apb master on the register side and a tcam that takes keys by valid/ready
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module eak_key_builder
  import eak_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // ----------------------------------------
  // classification request
  // ----------------------------------------
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [2:0] reqKeySel,
  input wire logic [GRP_W-1:0] reqAclGroupId,
  input wire logic reqProtectionActive,
  input wire logic [MAC_W-1:0] reqDestMac,
  input wire logic [SVC_IDX_W-1:0] reqIngressServiceIndex,
  input wire logic reqTaggedOnReceive,
  input wire logic [VID_W-1:0] reqClassifiedVlanId,
  // ----------------------------------------
  // key toward the tcam
  // ----------------------------------------
  output logic keyValid,
  input wire logic keyReady,
  output logic [KEY_W-1:0] keyData,
  output logic [3:0] keyWords,
  output logic keyFirst
);

  // ----------------------------------------
  // key assembly
  // ----------------------------------------
  logic [COMMON_W-1:0] commonFields;
  logic [KEY_W-1:0] placedKey;
  logic [3:0] placedWords;
  logic placedDefined;

  eak_common_fields u_common (
    .aclGroupId(reqAclGroupId),
    .protectionActive(reqProtectionActive),
    .destMac(reqDestMac),
    .ingressServiceIndex(reqIngressServiceIndex),
    .taggedOnReceive(reqTaggedOnReceive),
    .classifiedVlanId(reqClassifiedVlanId),
    .commonFields(commonFields)
  );

  // first pass is always built first; the second is derived from it
  eak_key_place u_place (
    .keySel(reqKeySel),
    .firstLookup(1'b1),
    .commonFields(commonFields),
    .keyBits(placedKey),
    .keyWords(placedWords),
    .keyDefined(placedDefined)
  );

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [1:0] ctrl_reg;
  logic [1:0] ctrl_next;
  logic [31:0] frames_reg;
  logic [31:0] frames_next;
  logic [31:0] refused_reg;
  logic [31:0] refused_next;
  logic [31:0] keys_reg;
  logic [31:0] keys_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;

  // ----------------------------------------
  // lookup state
  // ----------------------------------------
  eak_state_t state_reg;
  eak_state_t state_next;
  logic [KEY_W-1:0] keyData_reg;
  logic [KEY_W-1:0] keyData_next;
  logic [3:0] keyWords_reg;
  logic [3:0] keyWords_next;
  logic keyFirst_reg;
  logic keyFirst_next;
  logic [2:0] sel_reg;
  logic [2:0] sel_next;

  logic apbSetup;
  logic apbWrite;
  logic addrMapped;
  logic reqTaken;
  logic keyTaken;
  logic ctrlEnable;
  logic ctrlSecond;

  assign ctrlEnable = ctrl_reg[CTRL_ENABLE_BIT];
  assign ctrlSecond = ctrl_reg[CTRL_SECOND_BIT];
  assign apbSetup = psel && !penable;
  // zero wait states: the access phase always completes
  assign apbWrite = psel && penable && pwrite;
  assign addrMapped = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) || (paddr == OFS_FRAMES) ||
                      (paddr == OFS_REFUSED) || (paddr == OFS_KEYS);

  // frame taken only when idle and enabled
  assign reqReady = (state_reg == EAK_IDLE) && ctrlEnable;
  assign reqTaken = reqValid && reqReady;
  assign keyValid = (state_reg != EAK_IDLE);
  assign keyTaken = keyValid && keyReady;

  // ----------------------------------------
  // apb next values
  // ----------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (apbSetup) begin
      // read data captured in setup so the access phase shows a flop
      pslverr_next = !addrMapped;
      case (paddr)
        OFS_CTRL: begin
          prdata_next = {30'h0, ctrl_reg};
        end
        OFS_STATUS: begin
          prdata_next = {21'h0, sel_reg, keyWords_reg, keyFirst_reg, state_reg};
        end
        OFS_FRAMES: begin
          prdata_next = frames_reg;
        end
        OFS_REFUSED: begin
          prdata_next = refused_reg;
        end
        OFS_KEYS: begin
          prdata_next = keys_reg;
        end
        default: begin
          prdata_next = 32'h0;
        end
      endcase
    end
    if (apbWrite && (paddr == OFS_CTRL)) begin
      ctrl_next = pwdata[1:0];
    end
  end

  // ----------------------------------------
  // lookup sequencing
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    keyData_next = keyData_reg;
    keyWords_next = keyWords_reg;
    keyFirst_next = keyFirst_reg;
    sel_next = sel_reg;
    case (state_reg)
      EAK_IDLE: begin
        if (reqTaken) begin
          if (placedDefined) begin
            keyData_next = placedKey;
            keyWords_next = placedWords;
            keyFirst_next = 1'b1;
            sel_next = reqKeySel;
            state_next = EAK_FIRST;
          end
        end
      end
      EAK_FIRST: begin
        if (keyTaken) begin
          if (ctrlSecond) begin
            keyFirst_next = 1'b0;
            if (eak_is_six_word(sel_reg)) begin
              keyData_next[FIRST_POS_WIDE] = 1'b0;
            end else begin
              keyData_next[FIRST_POS_NARROW] = 1'b0;
            end
            state_next = EAK_SECOND;
          end else begin
            state_next = EAK_IDLE;
          end
        end
      end
      EAK_SECOND: begin
        if (keyTaken) begin
          state_next = EAK_IDLE;
        end
      end
      default: begin
        state_next = EAK_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // apb registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= CTRL_RESET;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ----------------------------------------
  // event counters
  // ----------------------------------------
  // software-visible statistics, one event kind each
  logic frameKeyed;
  logic frameRefused;
  logic clearFrames;
  logic clearRefused;
  logic clearKeys;

  assign frameKeyed = reqTaken && placedDefined;
  // undefined selector: swallowed so the classifier never stalls on it
  assign frameRefused = reqTaken && !placedDefined;
  // any write clears, whatever the data
  assign clearFrames = apbWrite && (paddr == OFS_FRAMES);
  assign clearRefused = apbWrite && (paddr == OFS_REFUSED);
  assign clearKeys = apbWrite && (paddr == OFS_KEYS);

  always_comb begin
    frames_next = frames_reg;
    refused_next = refused_reg;
    keys_next = keys_reg;
    // a same-cycle event still counts after the clear, so no event is lost
    if (clearFrames) begin
      frames_next = 32'h0;
    end
    if (clearRefused) begin
      refused_next = 32'h0;
    end
    if (clearKeys) begin
      keys_next = 32'h0;
    end
    if (frameKeyed) begin
      frames_next = frames_next + 32'h1;
    end
    if (frameRefused) begin
      refused_next = refused_next + 32'h1;
    end
    if (keyTaken) begin
      keys_next = keys_next + 32'h1;
    end
  end

  // counters wrap silently; software reads and clears well before that
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      frames_reg <= 32'h0;
      refused_reg <= 32'h0;
      keys_reg <= 32'h0;
    end else begin
      frames_reg <= frames_next;
      refused_reg <= refused_next;
      keys_reg <= keys_next;
    end
  end

  // ----------------------------------------
  // lookup registers
  // ----------------------------------------
  // key held whole while keyValid waits for keyReady
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= EAK_IDLE;
      keyData_reg <= '0;
      keyWords_reg <= 4'h0;
      keyFirst_reg <= 1'b0;
      sel_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      keyData_reg <= keyData_next;
      keyWords_reg <= keyWords_next;
      keyFirst_reg <= keyFirst_next;
      sel_reg <= sel_next;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign pready = 1'b1;
  assign keyData = keyData_reg;
  assign keyWords = keyWords_reg;
  assign keyFirst = keyFirst_reg;

endmodule : eak_key_builder

// ==== verif/eak_tcam_model.sv ====
// tcam side model: takes keys at once or with stalls
// assumes keyValid is a level held until keyReady
`timescale 1ns/1ps
module eak_tcam_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic keyValid,
  input wire logic slowMode,
  output logic keyReady
);
  logic accept_reg;
  logic accept_next;
  always_comb begin
    // slow mode answers every other cycle, and only while a key waits
    accept_next = slowMode ? (keyValid && !accept_reg) : 1'b1;
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) accept_reg <= 1'b0;
    else accept_reg <= accept_next;
  end
  assign keyReady = accept_reg;
endmodule : eak_tcam_model

// ==== verif/eak_key_builder_sva.sv ====
// checker on the key builder ports
// assumes the package layout of six-word keys
`timescale 1ns/1ps
module eak_key_builder_sva
  import eak_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic [2:0] reqKeySel,
  input wire logic [GRP_W-1:0] reqAclGroupId,
  input wire logic reqProtectionActive,
  input wire logic [MAC_W-1:0] reqDestMac,
  input wire logic [SVC_IDX_W-1:0] reqIngressServiceIndex,
  input wire logic reqTaggedOnReceive,
  input wire logic [VID_W-1:0] reqClassifiedVlanId,
  input wire logic keyValid,
  input wire logic keyReady,
  input wire logic [KEY_W-1:0] keyData,
  input wire logic [3:0] keyWords,
  input wire logic keyFirst
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic take0;
  assign take0 = reqValid && reqReady && reqKeySel == 3'h0;
  a_words_legal: assert property (keyValid |-> keyWords inside {4'h3, 4'h6, 4'hc})
    else $error("key length illegal");
  a_six_type: assert property (keyValid && keyWords == 4'h6 |-> keyData[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h5})
    else $error("six word type code wrong");
  a_pass_bit: assert property (keyValid |-> keyFirst == (keyWords == 4'h6 ? keyData[4] : keyData[0]))
    else $error("pass flag misplaced");
  a_key_holds: assert property (keyValid && !keyReady |=> keyValid && $stable(keyData))
    else $error("key dropped before taken");
  a_upper_zero: assert property (keyValid |-> keyData[KEY_W-1:43] == '0)
    else $error("bits above key not zero");
  a_answer_time: assert property (reqValid && reqReady && reqKeySel != 3'h4 |=> keyValid && keyFirst)
    else $error("no first key after request");
  a_flags_six: assert property (take0 |=> keyData[16:13] == {$past(reqIngressServiceIndex) != 12'h000,
    &$past(reqDestMac), $past(reqDestMac[MC_BIT]), $past(reqProtectionActive)})
    else $error("flag bits wrong");
  a_fields_six: assert property (take0 |=> keyData[42:17] == {$past(reqClassifiedVlanId),
    $past(reqTaggedOnReceive), $past(reqIngressServiceIndex)} && keyData[12:5] == $past(reqAclGroupId))
    else $error("field bits wrong");
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("apb access not answered");
endmodule : eak_key_builder_sva
bind eak_key_builder eak_key_builder_sva chk (.*);

// ==== verif/tb.sv ====
// key builder testbench: apb tasks, frame requests, key compares
// assumes the tcam model answers on keyReady
`timescale 1ns/1ps
module tb;
  import eak_pkg::*;
  logic sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic reqValid = 0, reqReady, reqProtectionActive = 0, reqTaggedOnReceive = 0, slowMode = 0;
  logic [2:0] reqKeySel = '0;
  logic [GRP_W-1:0] reqAclGroupId = '0;
  logic [MAC_W-1:0] reqDestMac = '0;
  logic [SVC_IDX_W-1:0] reqIngressServiceIndex = '0;
  logic [VID_W-1:0] reqClassifiedVlanId = '0;
  logic keyValid, keyReady, keyFirst;
  logic [KEY_W-1:0] keyData;
  logic [3:0] keyWords;
  logic [COMMON_W-1:0] cf;
  logic [2:0] sels [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
  int errCount = 0, checkCount = 0;
  assign cf = {reqClassifiedVlanId, reqTaggedOnReceive, reqIngressServiceIndex, reqIngressServiceIndex != 12'h000,
               &reqDestMac, reqDestMac[MC_BIT], reqProtectionActive, reqAclGroupId};
  eak_key_builder dut (.*);
  eak_tcam_model tcam (.*);
  always #2 sys_clk = ~sys_clk;
  task check(input bit ok, input string msg);
    checkCount++;
    if (!ok) begin
      errCount++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task completeRun;
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : completeRun
  task timeout(input int n);
    if (n >= 50) begin
      errCount++;
      $display("mismatch at %0t: wait timed out", $time);
      completeRun();
    end
  endtask : timeout
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    timeout(n);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask : apb
  task sendReq(input logic [2:0] s, input int i);
    int n;
    n = 0;
    reqValid <= 1;
    reqKeySel <= s;
    reqAclGroupId <= 8'ha0 + 8'(i);
    reqProtectionActive <= i[0];
    reqTaggedOnReceive <= ~i[0];
    reqDestMac <= (i == 2) ? '1 : i[0] ? 48'h0100_0000_0000 | 48'(i) : 48'h00fe_1234_5678;
    reqIngressServiceIndex <= (i == 0) ? 12'h000 : (i == 6) ? 12'hfff : 12'h100 + 12'(i);
    reqClassifiedVlanId <= 13'h1000 + 13'(i);
    do begin
      @(negedge sys_clk);
      n++;
    end while (reqReady !== 1'b1 && n < 50);
    timeout(n);
    @(posedge sys_clk);
    reqValid <= 0;
  endtask : sendReq
  task getKey(input logic f);
    logic [KEY_W-1:0] k;
    logic [3:0] w;
    int n;
    n = 0;
    k = '0;
    w = (reqKeySel == 3'h6) ? WORDS_THREE : (reqKeySel == 3'h7) ? WORDS_TWELVE : WORDS_SIX;
    if (reqKeySel < 3'h6) k[42:0] = {cf, f, 1'b0, reqKeySel};
    else k[38:0] = {cf, f};
    do begin
      @(negedge sys_clk);
      n++;
    end while (!(keyValid === 1'b1 && keyReady === 1'b1) && n < 50);
    timeout(n);
    check(keyData === k && keyWords === w && keyFirst === f, "key content");
    @(posedge sys_clk);
  endtask : getKey
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1;
    @(posedge sys_clk);
    apb(0, OFS_CTRL, 0);
    check(rd === 32'h3 && er === 1'b0, "control reset value");
    apb(1, 8'h14, 32'h5);
    check(rd === 32'h0 && er === 1'b1, "unmapped access");
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      slowMode <= i[0];
      sendReq(sels[i], i);
      getKey(1);
      getKey(0);
    end
    $display("test variants done");
    sendReq(3'h4, 7);
    repeat (3) begin
      @(negedge sys_clk);
      check(keyValid === 1'b0, "undefined selector keyed");
    end
    @(posedge sys_clk);
    apb(0, OFS_REFUSED, 0);
    check(rd === 32'h1, "refused count");
    apb(0, OFS_FRAMES, 0);
    check(rd === 32'h7, "frame count");
    apb(0, OFS_KEYS, 0);
    check(rd === 32'he, "key count");
    apb(1, OFS_FRAMES, 0);
    apb(0, OFS_FRAMES, 0);
    check(rd === 32'h0 && er === 1'b0, "frame count not cleared");
    $display("test undefined done");
    apb(1, OFS_CTRL, 32'h1);
    sendReq(3'h6, 3);
    getKey(1);
    @(negedge sys_clk);
    check(keyValid === 1'b0, "second pass not off");
    @(posedge sys_clk);
    apb(0, OFS_STATUS, 0);
    check(rd === 32'h639 && er === 1'b0, "status word");
    apb(1, OFS_CTRL, 32'h0);
    @(negedge sys_clk);
    check(reqReady === 1'b0, "disabled yet ready");
    $display("test control done");
    completeRun();
  end
endmodule : tb
